/* core/aod_pkg.sv */
// aod_pkg: constants and types shared by the amplifier output diagnostic sequencer
// assumes pclk at 100 MHz and an APB master with 32-bit data
`default_nettype none

package aod_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] REPORT_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // timebase
  localparam int CLK_NS    = 10;
  localparam int MS_NS     = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  localparam int CHECK_MS  = 1;
  localparam int ACQ_MS    = 100;
  // one extra tick so the check never comes before a full millisecond
  localparam logic [6:0] CHECK_TICKS = 7'(CHECK_MS + 1);
  localparam logic [6:0] ACQ_TICKS   = 7'(ACQ_MS);

  localparam logic [1:0] AC_MIN_PULSES = 2'h3;

  // load class limits in milliohm: amplifier classes, then line-driver classes
  localparam logic [19:0] PA_SHORT_MOHM = 20'h001F4;
  localparam logic [19:0] PA_NMIN_MOHM  = 20'h005DC;
  localparam logic [19:0] PA_NMAX_MOHM  = 20'h0AFC8;
  localparam logic [19:0] PA_OPEN_MOHM  = 20'h14C08;
  localparam logic [19:0] LD_SHORT_MOHM = 20'h005DC;
  localparam logic [19:0] LD_NMIN_MOHM  = 20'h01194;
  localparam logic [19:0] LD_NMAX_MOHM  = 20'h2BF20;
  localparam logic [19:0] LD_OPEN_MOHM  = 20'h50910;

  // peak current limits in mA for the tweeter test
  localparam logic [9:0] AC_NORM_HI = 10'h1F4;
  localparam logic [9:0] AC_OPEN_HI = 10'h0FA;
  localparam logic [9:0] AC_NORM_LO = 10'h0FA;
  localparam logic [9:0] AC_OPEN_LO = 10'h07D;

  typedef enum logic [2:0] {
    FC_NONE    = 3'h0,
    FC_GND     = 3'h1,
    FC_VS      = 3'h2,
    FC_LSHORT  = 3'h3,
    FC_OPEN    = 3'h4,
    FC_OFFSET  = 3'h5,
    FC_TWEETER = 3'h6
  } aod_fcode_t;

  typedef enum logic [2:0] {
    CH_OFF     = 3'h0,
    CH_TURNON  = 3'h1,
    CH_ACTIVE  = 3'h2,
    CH_CHECK   = 3'h3,
    CH_DIAG    = 3'h4,
    CH_RESTART = 3'h5
  } aod_chst_t;

  typedef struct packed {
    logic       dbl;
    aod_fcode_t code;
  } aod_fault_t;

  // control register, bit 6 down to bit 0
  typedef struct packed {
    logic line_drv;
    logic low_gain;
    logic ac_current_threshold_select;
    logic ac_diag_enable;
    logic offset_detect_enable;
    logic amp_on;
    logic diag_en;
  } aod_ctrl_t;

  // analog comparator levels of one channel
  typedef struct packed {
    logic gnd;
    logic vs;
    logic lshort;
    logic lopen;
    logic ovl;
    logic ofs;
    logic ipk;
  } aod_ana_t;

  typedef struct packed {
    aod_chst_t  st;
    logic [6:0] tmr;
    logic       spent;
    aod_fault_t ton;
    aod_fault_t dc;
    logic       ofs_all;
    logic       sup;
    logic [1:0] npk;
    aod_fault_t rep;
  } aod_ch_t;

endpackage

`default_nettype wire

/* core/aod_diag_seq.sv */
// aod_diag_seq: two-channel output diagnostic sequencer with APB register access
// assumes analog comparator levels arrive asynchronously and are synchronised here
//
// Chosen here: the register addresses and the APB register port.
`default_nettype none

//
// Contract
// - turn-on result held until next pulse
// - joint exit and enable: pulse first, stages off
// - turn-on result kept until output short
// - sample fault at plateau end, 100 ms
// - ground and supply shorts ignore gain
// - low gain line-driver uses line-driver classes
// - restart mode: faulty channel off, recheck 1 ms
// - overload gone at 1 ms check: reactivate
// - overload persists: 100 ms cycle then restart
// - next permanent cycle only after host read
// - offset flagged only if persistent whole window
// - window opens at read or enable, closes at read
// - overload suppresses offset and AC diagnostics
// - AC test only while enabled, peak current
// - threshold select picks 500/250 or 250/125 mA
// - three pulses mean tweeter present, else open
// - multiple faults reported one per read
// - short with open speaker reports the short alone
// - ground plus supply both; ground hides load
// - every read restarts cycles, returns previous result; here only reads at REPORT_OFS do
module aod_diag_seq #(
  parameter int MS_TICK_CYCLES = aod_pkg::MS_CYCLES
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire aod_pkg::aod_ana_t [1:0]  ana,
  output logic      [1:0]               power_stage_en,
  output logic      [1:0]               test_pulse_en,
  output logic      [19:0]              load_short_lim_mohm,
  output logic      [19:0]              load_norm_min_mohm,
  output logic      [19:0]              load_norm_max_mohm,
  output logic      [19:0]              load_open_lim_mohm,
  output logic      [9:0]               ac_normal_ma,
  output logic      [9:0]               ac_open_ma
);

  typedef struct packed {
    aod_pkg::aod_ctrl_t      ctrl;
    aod_pkg::aod_ch_t [1:0]  ch;
    logic [19:0]             mscnt;
    logic                    tick;
    aod_pkg::aod_ana_t [1:0] s1;
    aod_pkg::aod_ana_t [1:0] s2;
    aod_pkg::aod_ana_t [1:0] s3;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
    logic [1:0]              pse;
    logic [1:0]              tpe;
    logic [19:0]             lshort;
    logic [19:0]             lnmin;
    logic [19:0]             lnmax;
    logic [19:0]             lopen;
    logic [9:0]              acn;
    logic [9:0]              aco;
  } aod_st_t;

  localparam aod_st_t ST_RST = '0;

  aod_st_t            r;
  aod_st_t            n;
  logic               acc;
  logic               wr;
  logic               rd;
  logic               pulse_req;
  logic               win_open;
  logic               ac_start;
  aod_pkg::aod_ctrl_t wctrl;

  // fault class at the end of a test current plateau
  function automatic aod_pkg::aod_fault_t classify(input aod_pkg::aod_ana_t a, input logic turnon);
    aod_pkg::aod_fault_t f;
    f.dbl  = 1'b0;
    f.code = aod_pkg::FC_NONE;
    // level comparators are gain independent; only the load limits move
    if (a.gnd) begin
      f.code = aod_pkg::FC_GND;
      f.dbl  = a.vs;
    end else if (a.vs) begin
      f.code = aod_pkg::FC_VS;
    end else if (a.lshort) begin
      f.code = aod_pkg::FC_LSHORT;
    end else if (a.lopen && turnon) begin
      f.code = aod_pkg::FC_OPEN;
    end
    return f;
  endfunction

  // one fault per read; lower ones surface once the higher is removed
  function automatic aod_pkg::aod_fault_t report(input aod_pkg::aod_ch_t c, input aod_pkg::aod_ctrl_t k);
    aod_pkg::aod_fault_t f;
    f = c.dc;
    if (c.dc.code == aod_pkg::FC_NONE) begin
      if (c.ton.code != aod_pkg::FC_NONE) begin
        f = c.ton;
      end else if (k.offset_detect_enable && c.ofs_all && !c.sup) begin
        f.code = aod_pkg::FC_OFFSET;
      end else if (k.ac_diag_enable && !c.sup && c.npk != aod_pkg::AC_MIN_PULSES) begin
        f.code = aod_pkg::FC_TWEETER;
      end
    end
    return f;
  endfunction

  assign acc       = psel && penable && r.pready;
  assign wr        = acc && pwrite && paddr == aod_pkg::CTRL_OFS && pstrb[0];
  assign rd        = acc && !pwrite && paddr == aod_pkg::REPORT_OFS;
  assign wctrl     = aod_pkg::aod_ctrl_t'(pwdata[6:0]);
  assign pulse_req = wr && wctrl.amp_on && !r.ctrl.amp_on && wctrl.diag_en;
  assign win_open  = rd || (wr && wctrl.offset_detect_enable && !r.ctrl.offset_detect_enable);
  assign ac_start  = wr && wctrl.ac_diag_enable && !r.ctrl.ac_diag_enable;

  always_comb begin
    logic                ld;
    logic                expire;
    logic                pk_rise;
    aod_pkg::aod_ana_t   a;
    aod_pkg::aod_fault_t f;
    ld      = 1'b0;
    expire  = 1'b0;
    pk_rise = 1'b0;
    a       = r.s2[0];
    f       = r.ch[0].dc;
    n       = r;

    // free-running millisecond timebase
    n.tick  = r.mscnt == 20'(MS_TICK_CYCLES - 1);
    n.mscnt = n.tick ? 20'h00000 : r.mscnt + 20'h00001;

    // comparator levels are asynchronous; stage two feeds logic, stage three edges
    n.s1 = ana;
    n.s2 = r.s1;
    n.s3 = r.s2;

    // answer in the first access cycle, data latched at setup
    n.pready  = psel && !penable;
    n.pslverr = 1'b0;
    n.prdata  = 32'h00000000;
    if (psel && !penable) begin
      case (paddr)
        aod_pkg::CTRL_OFS: begin
          n.prdata = {25'h0000000, r.ctrl};
        end
        aod_pkg::REPORT_OFS: begin
          // value from the cycle that ended with the previous read
          n.prdata = {20'h00000, r.ch[1].rep, 4'h0, r.ch[0].rep};
        end
        aod_pkg::STATUS_OFS: begin
          n.prdata = {19'h00000, r.ctrl.amp_on, 2'h0, r.ch[1].spent, r.ch[0].spent,
                      1'b0, r.ch[1].st, 1'b0, r.ch[0].st};
        end
        default: begin
          n.pslverr = 1'b1;
        end
      endcase
    end

    if (wr) begin
      n.ctrl = wctrl;
    end

    // limits handed to the analog comparators
    ld       = n.ctrl.low_gain && n.ctrl.line_drv;
    n.lshort = ld ? aod_pkg::LD_SHORT_MOHM : aod_pkg::PA_SHORT_MOHM;
    n.lnmin  = ld ? aod_pkg::LD_NMIN_MOHM : aod_pkg::PA_NMIN_MOHM;
    n.lnmax  = ld ? aod_pkg::LD_NMAX_MOHM : aod_pkg::PA_NMAX_MOHM;
    n.lopen  = ld ? aod_pkg::LD_OPEN_MOHM : aod_pkg::PA_OPEN_MOHM;
    n.acn    = n.ctrl.ac_current_threshold_select ? aod_pkg::AC_NORM_LO : aod_pkg::AC_NORM_HI;
    n.aco    = n.ctrl.ac_current_threshold_select ? aod_pkg::AC_OPEN_LO : aod_pkg::AC_OPEN_HI;

    for (int i = 0; i < 2; i++) begin
      a       = r.s2[i];
      pk_rise = a.ipk && !r.s3[i].ipk;
      expire  = r.tick && r.ch[i].tmr == 7'h01;
      if (r.tick && r.ch[i].tmr != 7'h00) begin
        n.ch[i].tmr = r.ch[i].tmr - 7'h01;
      end

      // offset window: only a level held all window long survives
      n.ch[i].ofs_all = r.ch[i].ofs_all && a.ofs;
      if (pk_rise && r.ctrl.ac_diag_enable && r.ch[i].npk != aod_pkg::AC_MIN_PULSES) begin
        n.ch[i].npk = r.ch[i].npk + 2'h1;
      end

      // a read closes every measurement and starts the next
      if (rd) begin
        n.ch[i].rep   = report(r.ch[i], r.ctrl);
        n.ch[i].dc    = '0;
        n.ch[i].spent = 1'b0;
        n.ch[i].sup   = 1'b0;
        n.ch[i].npk   = {1'b0, pk_rise && r.ctrl.ac_diag_enable};
      end
      if (ac_start) begin
        n.ch[i].npk = 2'h0;
        n.ch[i].sup = 1'b0;
      end
      if (win_open) begin
        n.ch[i].ofs_all = 1'b1;
        // an overload from before the window must not mask it; the flag is
        // shared with the tone test, so a running tone test keeps it
        if (!r.ctrl.ac_diag_enable) begin
          n.ch[i].sup = 1'b0;
        end
      end
      // set after the clears so an overload in a read cycle is kept
      if (a.ovl) begin
        n.ch[i].sup = 1'b1;
      end

      case (r.ch[i].st)
        aod_pkg::CH_OFF: begin
          if (pulse_req) begin
            n.ch[i].st  = aod_pkg::CH_TURNON;
            n.ch[i].tmr = aod_pkg::ACQ_TICKS;
          end else if (n.ctrl.amp_on) begin
            n.ch[i].st = aod_pkg::CH_ACTIVE;
          end
        end
        aod_pkg::CH_TURNON: begin
          if (expire) begin
            n.ch[i].ton = classify(a, 1'b1);
            n.ch[i].st  = aod_pkg::CH_ACTIVE;
          end
        end
        aod_pkg::CH_ACTIVE: begin
          if (a.ovl) begin
            if (r.ctrl.diag_en && !r.ch[i].spent) begin
              n.ch[i].st  = aod_pkg::CH_CHECK;
              n.ch[i].tmr = aod_pkg::CHECK_TICKS;
            end else begin
              n.ch[i].st = aod_pkg::CH_RESTART;
            end
          end
        end
        aod_pkg::CH_CHECK: begin
          if (expire) begin
            if (a.ovl) begin
              n.ch[i].st  = aod_pkg::CH_DIAG;
              n.ch[i].tmr = aod_pkg::ACQ_TICKS;
            end else begin
              // a recirculation spike only: no diagnostic
              n.ch[i].st = aod_pkg::CH_ACTIVE;
            end
          end
        end
        aod_pkg::CH_DIAG: begin
          if (expire) begin
            f             = classify(a, 1'b0);
            n.ch[i].dc    = f;
            n.ch[i].spent = 1'b1;
            n.ch[i].st    = aod_pkg::CH_RESTART;
            if (f.code != aod_pkg::FC_NONE) begin
              n.ch[i].ton = '0;
            end
          end
        end
        aod_pkg::CH_RESTART: begin
          // recheck once per millisecond, the other channel keeps playing
          if (r.tick && !a.ovl) begin
            n.ch[i].st = aod_pkg::CH_ACTIVE;
          end
        end
        default: begin
          n.ch[i].st = aod_pkg::CH_OFF;
        end
      endcase

      if (!n.ctrl.amp_on) begin
        n.ch[i].st  = aod_pkg::CH_OFF;
        n.ch[i].tmr = 7'h00;
      end

      // stages stay high impedance except in normal play
      n.pse[i] = n.ch[i].st == aod_pkg::CH_ACTIVE;
      n.tpe[i] = n.ch[i].st == aod_pkg::CH_TURNON || n.ch[i].st == aod_pkg::CH_DIAG;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= ST_RST;
    end else begin
      r <= n;
    end
  end

  assign prdata              = r.prdata;
  assign pready              = r.pready;
  assign pslverr             = r.pslverr;
  assign power_stage_en      = r.pse;
  assign test_pulse_en       = r.tpe;
  assign load_short_lim_mohm = r.lshort;
  assign load_norm_min_mohm  = r.lnmin;
  assign load_norm_max_mohm  = r.lnmax;
  assign load_open_lim_mohm  = r.lopen;
  assign ac_normal_ma        = r.acn;
  assign ac_open_ma          = r.aco;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_TURNON_HIGHZ:
    assert property (r.ch[0].st == aod_pkg::CH_TURNON |-> !power_stage_en[0] && test_pulse_en[0])
    else $error("power stage driven during turn-on pulse");

  AST_PULSE_FIRST:
    assert property (pulse_req && r.ch[0].st == aod_pkg::CH_OFF |=> r.ch[0].st == aod_pkg::CH_TURNON)
    else $error("joint standby exit and enable did not start the pulse");

  AST_ONLY_FAULTY:
    assert property (r.ch[0].st == aod_pkg::CH_RESTART && r.ch[1].st == aod_pkg::CH_ACTIVE
                     |-> power_stage_en == 2'b10)
    else $error("restart did not shut down only the faulty channel");

  AST_CHECK_CLEAR:
    assert property (r.ch[0].st == aod_pkg::CH_CHECK && r.tick && r.ch[0].tmr == 7'h01 && !r.s2[0].ovl
                     && n.ctrl.amp_on |=> r.ch[0].st == aod_pkg::CH_ACTIVE && power_stage_en[0])
    else $error("channel not reactivated after clean check");

  AST_CHECK_HELD:
    assert property (r.ch[0].st == aod_pkg::CH_CHECK && r.tick && r.ch[0].tmr == 7'h01 && r.s2[0].ovl
                     && n.ctrl.amp_on |=> r.ch[0].st == aod_pkg::CH_DIAG && r.ch[0].tmr == 7'h64)
    else $error("persistent overload did not start a 100 ms cycle");

  AST_ACQ_LEN:
    assert property ($rose(r.ch[0].st == aod_pkg::CH_TURNON) |-> r.ch[0].tmr == 7'h64)
    else $error("turn-on acquisition not 100 ticks");

  AST_DIAG_ONCE:
    assert property (r.ch[0].st == aod_pkg::CH_RESTART && $past(r.ch[0].st) == aod_pkg::CH_DIAG
                     |-> r.ch[0].spent && !test_pulse_en[0])
    else $error("diagnostic cycle not closed until the next read");

  AST_OFS_PERSIST:
    assert property (!r.s2[0].ofs && !win_open |=> !r.ch[0].ofs_all)
    else $error("offset kept although it dropped inside the window");

  AST_OVL_SUPPRESS:
    assert property (r.s2[0].ovl |=> r.ch[0].sup)
    else $error("overload did not suppress offset and AC results");

  AST_AC_THRESH:
    assert property (r.ctrl.ac_current_threshold_select |-> ac_normal_ma == 10'h0FA && ac_open_ma == 10'h07D)
    else $error("low current thresholds wrong");

  AST_GND_VS_BOTH:
    assert property (r.ch[0].st == aod_pkg::CH_TURNON && r.tick && r.ch[0].tmr == 7'h01 && r.ctrl.amp_on
                     && r.s2[0].gnd && r.s2[0].vs |=> r.ch[0].ton.dbl && r.ch[0].ton.code == aod_pkg::FC_GND)
    else $error("ground plus supply short not reported as both");

  AST_READ_OLD:
    assert property (rd && r.ch[0].dc.code != aod_pkg::FC_NONE |=> r.ch[0].rep == $past(r.ch[0].dc)
                     ##1 r.ch[0].dc.code == aod_pkg::FC_NONE || r.ch[0].st == aod_pkg::CH_DIAG
                     || r.ch[0].st == aod_pkg::CH_RESTART)
    else $error("read did not return the previous cycle result");

endmodule // aod_diag_seq

`default_nettype wire

/* test/aod_host.sv */
// aod_host: APB master standing in for the host controller
// assumes a slave that answers each transfer with pready
`default_nettype none

module aod_host (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    pstrb   = 4'hF;
  end

  // request held until pready is seen at an edge; only the bench watchdog ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
endmodule // aod_host

`default_nettype wire

/* test/tb.sv */
// tb: self-checking bench for the output diagnostic sequencer
// assumes aod_host as APB master and comparator levels driven here
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int TK = 20;

  logic                    pclk = 1'h0;
  logic                    presetn = 1'h0;
  logic                    psel, penable, pwrite, pready, pslverr;
  logic [7:0]              paddr;
  logic [31:0]             pwdata, prdata, q;
  logic [3:0]              pstrb;
  logic                    e;
  aod_pkg::aod_ana_t [1:0] ana = '0;
  logic [1:0]              power_stage_en, test_pulse_en;
  logic [19:0]             lsl, lnmin, lnmax, lol;
  logic [9:0]              acn, aco;
  int                      err_count = 0;
  int                      checked = 0;

  always #5 pclk = ~pclk;

  aod_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  aod_diag_seq #(.MS_TICK_CYCLES(TK)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ana(ana),
    .power_stage_en(power_stage_en), .test_pulse_en(test_pulse_en),
    .load_short_lim_mohm(lsl), .load_norm_min_mohm(lnmin), .load_norm_max_mohm(lnmax),
    .load_open_lim_mohm(lol), .ac_normal_ma(acn), .ac_open_ma(aco));

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'h1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    host.xfer(1'h0, a, 32'h0, q, e);
    chk(q & m, exp);
  endtask

  task automatic ticks(input int n);
    repeat (n * TK) @(posedge pclk);
  endtask

  // one tone cycle gives one current peak above the normal threshold
  task automatic peaks(input int n);
    repeat (n) begin
      @(posedge pclk);
      ana[0].ipk <= 1'h1;
      repeat (3) @(posedge pclk);
      ana[0].ipk <= 1'h0;
      repeat (3) @(posedge pclk);
    end
  endtask

  task automatic conclude;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    #1;
    chk({lsl, lnmin, lnmax, lol}, {20'h001F4, 20'h005DC, 20'h0AFC8, 20'h14C08});
    chk({acn, aco}, {10'h1F4, 10'h0FA});
    rd(8'h00, 32'h0, '1);
    rd(8'h08, 32'h0, '1);
    host.xfer(1'h0, 8'h0C, 32'h0, q, e);
    chk({e, q}, {1'h1, 32'h0});
    $display("test reset done");

    @(posedge pclk);
    ana[0].gnd    <= 1'h1;
    ana[0].vs     <= 1'h1;
    ana[1].gnd    <= 1'h1;
    ana[1].lshort <= 1'h1;
    repeat (4) @(posedge pclk);
    wr(8'h00, 32'h3);
    #1;
    chk({power_stage_en, test_pulse_en}, 4'h3);
    ticks(50);
    rd(8'h08, 32'h1011, '1);
    ticks(60);
    rd(8'h08, 32'h1022, '1);
    @(posedge pclk);
    ana <= '0;
    rd(8'h04, 32'h0, '1);
    rd(8'h04, 32'h0109, '1);
    rd(8'h04, 32'h0109, '1);
    $display("test turn-on done");

    wr(8'h00, 32'h73);
    @(posedge pclk);
    #1;
    chk({lsl, lnmin, lnmax, lol}, {20'h005DC, 20'h01194, 20'h2BF20, 20'h50910});
    chk({acn, aco}, {10'h0FA, 10'h07D});
    wr(8'h00, 32'h23);
    @(posedge pclk);
    #1;
    chk({lsl, lnmin, lnmax, lol}, {20'h001F4, 20'h005DC, 20'h0AFC8, 20'h14C08});
    chk({acn, aco}, {10'h1F4, 10'h0FA});
    wr(8'h00, 32'h3);
    $display("test thresholds done");

    @(posedge pclk);
    ana[0].ovl <= 1'h1;
    ana[0].vs  <= 1'h1;
    ticks(4);
    rd(8'h08, 32'h1024, '1);
    chk({power_stage_en, test_pulse_en}, 4'h9);
    ticks(102);
    rd(8'h08, 32'h1125, '1);
    rd(8'h04, 32'h0109, '1);
    rd(8'h04, 32'h0102, '1);
    rd(8'h08, 32'h1025, '1);
    @(posedge pclk);
    ana <= '0;
    ticks(3);
    rd(8'h08, 32'h1022, '1);
    @(posedge pclk);
    ana[1].ovl <= 1'h1;
    repeat (5) @(posedge pclk);
    ana[1].ovl <= 1'h0;
    ticks(4);
    rd(8'h08, 32'h1022, '1);
    $display("test permanent done");

    @(posedge pclk);
    ana[0].ofs <= 1'h1;
    repeat (4) @(posedge pclk);
    wr(8'h00, 32'h7);
    ticks(2);
    rd(8'h04, 32'h0, 32'hF);
    @(posedge pclk);
    ana[0].ofs <= 1'h0;
    repeat (4) @(posedge pclk);
    ana[0].ofs <= 1'h1;
    ticks(2);
    rd(8'h04, 32'h5, 32'hF);
    rd(8'h04, 32'h0, 32'hF);
    $display("test offset done");

    @(posedge pclk);
    ana[0].ofs <= 1'h0;
    wr(8'h00, 32'hB);
    ticks(2);
    rd(8'h04, 32'h5, 32'hF);
    peaks(3);
    rd(8'h04, 32'h6, 32'hF);
    peaks(2);
    rd(8'h04, 32'h0, 32'hF);
    rd(8'h04, 32'h6, 32'hF);
    wr(8'h00, 32'h3);
    rd(8'h04, 32'h6, 32'hF);
    rd(8'h04, 32'h0, 32'hF);
    $display("test ac done");

    ticks(501);
    rd(8'h04, 32'h0, 32'hF);
    wr(8'h00, 32'h0);
    rd(8'h08, 32'h0, '1);
    // a fresh pulse replaces the held turn-on result
    @(posedge pclk);
    ana[0].lopen  <= 1'h1;
    ana[1].lshort <= 1'h1;
    repeat (4) @(posedge pclk);
    wr(8'h00, 32'h3);
    ticks(102);
    ana <= '0;
    rd(8'h04, 32'h0100, '1);
    rd(8'h04, 32'h0304, '1);
    $display("test standby done");
    conclude();
  end

  // the tests need about 17000 cycles
  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    conclude();
  end
endmodule // tb

`default_nettype wire
